// ==== design/isa_mode_decode.sv ====
// Encoding mode flag, its switching on jumps and exceptions, and instruction format decode.
// Assumes the pipeline presents one retiring event per cycle at most, and fetch words with
// a valid strobe; straps are asynchronous pins and are synchronised here.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module isa_mode_decode
(
   input wire logic clock,
   input wire logic rst,
   // Straps from outside the core
   input wire logic [1:0] encodingsStrap,
   input wire logic excEncodingStrap,
   input wire logic debugEncodingStrap,
   // Software register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [31:0] regRdData,
   // Debug probe access to the debug control register
   input wire logic probeWrStrobe,
   input wire logic [31:0] probeWrData,
   output logic [31:0] probeRdData,
   // Retirement events from the pipeline
   input wire isa_mode_pkg::retire_t retireIn,
   output isa_mode_pkg::result_t resultOut,
   // Fetch words to decode
   input wire logic fetchValid,
   input wire logic [31:0] fetchWord,
   input wire logic bigEndian,
   output isa_mode_pkg::decode_t decodeOut,
   // Current mode toward fetch
   output logic modeFlag,
   output logic bootDone
);

   // Synchroniser stages for the straps
   logic [3:0] strapMeta;
   logic [3:0] strapSync;
   // Captured configuration
   logic [1:0] encodingsField_reg;
   logic excSel_reg;
   logic debugSel_reg;
   logic mode_reg;
   logic mode_next;
   logic [1:0] settleCount_reg;
   isa_mode_pkg::boot_state_t bootState_reg;
   logic bothEncodings;
   logic fixedMode;
   isa_mode_pkg::result_t result_next;
   isa_mode_pkg::decode_t decode_next;
   logic [31:0] cfgThreeView;
   logic [31:0] debugCtlView;

   // Two-flop synchroniser; the first stage feeds only the second
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         strapMeta <= 4'h0;
         strapSync <= 4'h0;
      end
      else
      begin
         strapMeta <= {debugEncodingStrap, excEncodingStrap, encodingsStrap};
         strapSync <= strapMeta;
      end
   end

   // Boot sequencer: wait for the synchroniser to settle, then latch straps once
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bootState_reg <= isa_mode_pkg::BOOT_WAIT;
         settleCount_reg <= 2'h0;
      end
      else
      begin
         case (bootState_reg)
            isa_mode_pkg::BOOT_WAIT:
            begin
               settleCount_reg <= settleCount_reg + 2'h1;
               if (settleCount_reg == isa_mode_pkg::BOOT_SETTLE_CYCLES - 2'h1)
                  bootState_reg <= isa_mode_pkg::BOOT_LOAD;
            end
            isa_mode_pkg::BOOT_LOAD:
               bootState_reg <= isa_mode_pkg::BOOT_RUN;
            isa_mode_pkg::BOOT_RUN:
               bootState_reg <= isa_mode_pkg::BOOT_RUN;
            default:
               bootState_reg <= isa_mode_pkg::BOOT_WAIT;
         endcase
      end
   end

   assign bootDone = (bootState_reg == isa_mode_pkg::BOOT_RUN);

   // Implemented-encodings field is read-only; the pin value is sampled at boot only
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         encodingsField_reg <= isa_mode_pkg::ENC_BASE_ONLY;
      else if (bootState_reg == isa_mode_pkg::BOOT_LOAD)
         encodingsField_reg <= strapSync[1:0];
   end

   assign bothEncodings = encodingsField_reg[1];
   // With one encoding the low bit names it; with both it names the boot mode
   assign fixedMode = encodingsField_reg[0];

   // Exception handler encoding: strap at boot, software writes later
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         excSel_reg <= isa_mode_pkg::SEL_RESET;
      else if (bootState_reg == isa_mode_pkg::BOOT_LOAD)
         excSel_reg <= strapSync[2];
      else if (regWrStrobe && regAddr == isa_mode_pkg::CFG_THREE_OFFSET)
         excSel_reg <= regWrData[isa_mode_pkg::EXC_SEL_BIT];
   end

   // Debug handler encoding: strap at boot, probe writes later
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         debugSel_reg <= isa_mode_pkg::SEL_RESET;
      else if (bootState_reg == isa_mode_pkg::BOOT_LOAD)
         debugSel_reg <= strapSync[3];
      else if (probeWrStrobe)
         debugSel_reg <= probeWrData[isa_mode_pkg::DBG_SEL_BIT];
   end

   // Register views; the mode itself is read back at DBG_MODE_BIT of the debug control register
   always_comb
   begin
      cfgThreeView = 32'h0000_0000;
      cfgThreeView[isa_mode_pkg::ENC_FIELD_MSB:isa_mode_pkg::ENC_FIELD_LSB] =
         encodingsField_reg;
      cfgThreeView[isa_mode_pkg::EXC_SEL_BIT] = excSel_reg;
      debugCtlView = 32'h0000_0000;
      debugCtlView[isa_mode_pkg::DBG_SEL_BIT] = debugSel_reg;
      debugCtlView[isa_mode_pkg::DBG_MODE_BIT] = mode_reg;
   end

   // Read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         regRdData <= 32'h0000_0000;
      else if (regRdStrobe)
      begin
         case (regAddr)
            isa_mode_pkg::CFG_THREE_OFFSET: regRdData <= cfgThreeView;
            isa_mode_pkg::DEBUG_CTL_OFFSET: regRdData <= debugCtlView;
            default: regRdData <= 32'h0000_0000;
         endcase
      end
      else
         regRdData <= 32'h0000_0000;
   end

   // Probe sees the debug control register continuously
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         probeRdData <= 32'h0000_0000;
      else
         probeRdData <= debugCtlView;
   end

   // Next mode and retirement answer
   always_comb
   begin
      mode_next = mode_reg;
      result_next = '0;
      result_next.valid = retireIn.valid;
      result_next.linkBit0 = mode_reg;
      result_next.savedMode = mode_reg;
      // Bit 0 never reaches the program counter
      result_next.targetPc = {retireIn.srcValue[31:1], 1'b0};
      if (bootState_reg == isa_mode_pkg::BOOT_LOAD)
         mode_next = strapSync[0];
      else if (retireIn.valid && bootDone)
      begin
         case (retireIn.kind)
            isa_mode_pkg::JUMP_LINK_EXCHANGE:
            begin
               if (bothEncodings)
                  mode_next = ~mode_reg;
               else
                  result_next.reservedInstrExc = 1'b1;
            end
            isa_mode_pkg::JUMP_VIA_REGISTER,
            isa_mode_pkg::JUMP_VIA_REGISTER_BARRIER,
            isa_mode_pkg::JUMP_LINK_VIA_REGISTER,
            isa_mode_pkg::JUMP_LINK_VIA_REGISTER_BARRIER:
            begin
               if (bothEncodings)
                  mode_next = retireIn.srcValue[0];
               else
                  result_next.addrExcOnFetch =
                     (retireIn.srcValue[0] != fixedMode);
               // Link value carries the mode before the jump
               result_next.linkBit0 = mode_reg;
            end
            isa_mode_pkg::EXC_ENTRY,
            isa_mode_pkg::ERROR_ENTRY:
            begin
               result_next.savedMode = mode_reg;
               if (bothEncodings)
               begin
                  // Fixed vectors outside the base keep the boot encoding
                  if (retireIn.vectorFromBase)
                     mode_next = excSel_reg;
                  else
                     mode_next = fixedMode;
               end
            end
            isa_mode_pkg::DEBUG_ENTRY:
            begin
               result_next.savedMode = mode_reg;
               if (bothEncodings)
                  mode_next = debugSel_reg;
            end
            isa_mode_pkg::EXC_RETURN:
            begin
               if (bothEncodings)
                  mode_next = retireIn.retPcBit0;
            end
            isa_mode_pkg::COP_OP:
               // Same outcome in either encoding, never a reserved trap
               result_next.copUnusableExc =
                  ~isa_mode_pkg::COP_IMPLEMENTED[retireIn.copNum];
            default:
               mode_next = mode_reg;
         endcase
      end
      if (bootDone && !bothEncodings)
         mode_next = fixedMode;
   end

   // Mode flag: one register, moves only at boot or retirement
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         mode_reg <= isa_mode_pkg::MODE_RESET;
      else
         mode_reg <= mode_next;
   end

   assign modeFlag = mode_reg;

   // Retirement answer registered, one cycle after the event
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         resultOut <= '0;
      else
         resultOut <= result_next;
   end

   // Format decode of the fetched word
   always_comb
   begin
      logic [15:0] firstHalf;
      logic [15:0] secondHalf;
      logic [31:0] instr;
      logic [5:0] major;
      logic isPool;
      logic isJump;
      logic [25:0] rawImm;
      logic [31:0] extImm;
      firstHalf = 16'h0000;
      secondHalf = 16'h0000;
      instr = 32'h0000_0000;
      major = 6'h00;
      isPool = 1'b0;
      isJump = 1'b0;
      rawImm = 26'h000_0000;
      extImm = 32'h0000_0000;
      decode_next = '0;
      decode_next.valid = fetchValid;
      // Halfword order follows endianness
      firstHalf = bigEndian ? fetchWord[31:16] : fetchWord[15:0];
      secondHalf = bigEndian ? fetchWord[15:0] : fetchWord[31:16];
      if (mode_reg == isa_mode_pkg::MODE_COMP)
      begin
         // Major opcode halfword leads, so it forms the top of the word
         instr = {firstHalf, secondHalf};
         major = firstHalf[15:10];
         decode_next.length32 = !(major[2:0] == isa_mode_pkg::SHORT_LOW_A ||
            major[2:0] == isa_mode_pkg::SHORT_LOW_B ||
            major[2:0] == isa_mode_pkg::SHORT_LOW_C);
         isJump = (major == isa_mode_pkg::COMP_JUMP_A ||
            major == isa_mode_pkg::COMP_JUMP_B || major == isa_mode_pkg::COMP_JUMP_C);
      end
      else
      begin
         instr = fetchWord;
         major = fetchWord[31:26];
         decode_next.length32 = 1'b1;
         isJump = (major == isa_mode_pkg::BASE_JUMP_A || major == isa_mode_pkg::BASE_JUMP_B);
      end
      decode_next.majorOpcode = major;
      isPool = (major[2:0] == isa_mode_pkg::POOL_LOW_BITS);
      if (decode_next.length32)
      begin
         // Register fields at fixed positions, 5 bits each
         decode_next.regField[0] = instr[25:21];
         decode_next.regField[1] = instr[20:16];
         decode_next.regField[2] = instr[15:11];
         decode_next.regField[3] = instr[10:6];
         if (isJump)
         begin
            decode_next.regCount = 3'h0;
            decode_next.immRightAligned = 1'b1;
            rawImm = instr[25:0];
            extImm = {{6{rawImm[25]}}, rawImm};
         end
         else if (major == isa_mode_pkg::MAJOR_REG_POOL)
         begin
            decode_next.regCount = 3'h4;
            decode_next.minorAtLow = 1'b1;
            decode_next.minorOpcode = instr[5:0];
         end
         else if (isPool)
         begin
            // Others put the minor field between the register fields and the immediate
            decode_next.regCount = 3'h2;
            decode_next.minorAtTwelve = 1'b1;
            decode_next.minorOpcode = {2'h0, instr[15:12]};
            rawImm = {14'h0000, instr[11:0]};
            extImm = {{20{instr[11]}}, instr[11:0]};
         end
         else
         begin
            decode_next.regCount = 3'h2;
            decode_next.immRightAligned = 1'b1;
            rawImm = {10'h000, instr[15:0]};
            extImm = {{16{instr[15]}}, instr[15:0]};
         end
      end
      else
      begin
         // Short forms: 3-bit fields widened, mapping done downstream
         decode_next.regCount = 3'h2;
         decode_next.regField[0] = {2'h0, firstHalf[9:7]};
         decode_next.regField[1] = {2'h0, firstHalf[6:4]};
         decode_next.regField[2] = 5'h00;
         decode_next.regField[3] = 5'h00;
         decode_next.immRightAligned = 1'b1;
         rawImm = {16'h0000, firstHalf[9:0]};
         extImm = {{22{firstHalf[9]}}, firstHalf[9:0]};
      end
      // Offset scaling follows the current encoding
      if (mode_reg == isa_mode_pkg::MODE_COMP)
         decode_next.branchOffset = extImm << isa_mode_pkg::COMP_OFFSET_SHIFT;
      else
         decode_next.branchOffset = extImm << isa_mode_pkg::BASE_OFFSET_SHIFT;
   end

   // Decode answer registered, one cycle after the fetch word
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         decodeOut <= '0;
      else
         decodeOut <= decode_next;
   end

endmodule // isa_mode_decode

`default_nettype wire

// ==== design/isa_mode_pkg.sv ====
// Constants, types and register layout for the encoding mode and format decoder.
// Assumes one core clock domain; straps arrive asynchronously from outside the core.
package isa_mode_pkg;

   // Register offsets on the plain register port (byte addresses)
   localparam logic [7:0] CFG_THREE_OFFSET = 8'h00;
   localparam logic [7:0] DEBUG_CTL_OFFSET = 8'h04;

   // Field positions in cfg_reg_three
   localparam int ENC_FIELD_LSB = 14;
   localparam int ENC_FIELD_MSB = 15;
   localparam int EXC_SEL_BIT = 16;

   // Field positions in debug_port_control_reg
   localparam int DBG_SEL_BIT = 0;
   localparam int DBG_MODE_BIT = 1;

   // Implemented-encodings field values
   localparam logic [1:0] ENC_BASE_ONLY = 2'h0;
   localparam logic [1:0] ENC_COMP_ONLY = 2'h1;
   localparam logic [1:0] ENC_BOTH_BASE = 2'h2;
   localparam logic [1:0] ENC_BOTH_COMP = 2'h3;

   // Mode flag values
   localparam logic MODE_BASE = 1'b0;
   localparam logic MODE_COMP = 1'b1;

   // Values after reset
   localparam logic MODE_RESET = 1'b0;
   localparam logic SEL_RESET = 1'b0;
   localparam logic [1:0] BOOT_SETTLE_CYCLES = 2'h3;

   // Offset scaling
   localparam int BASE_OFFSET_SHIFT = 2;
   localparam int COMP_OFFSET_SHIFT = 1;

   // Major opcode classes
   localparam logic [5:0] MAJOR_REG_POOL = 6'h00;
   localparam logic [2:0] POOL_LOW_BITS = 3'h0;
   localparam logic [5:0] BASE_JUMP_A = 6'h02;
   localparam logic [5:0] BASE_JUMP_B = 6'h03;
   localparam logic [5:0] COMP_JUMP_A = 6'h35;
   localparam logic [5:0] COMP_JUMP_B = 6'h3d;
   localparam logic [5:0] COMP_JUMP_C = 6'h3c;
   localparam logic [2:0] SHORT_LOW_A = 3'h1;
   localparam logic [2:0] SHORT_LOW_B = 3'h2;
   localparam logic [2:0] SHORT_LOW_C = 3'h3;

   // Coprocessors present: only the system coprocessor
   localparam logic [3:0] COP_IMPLEMENTED = 4'h1;

   typedef enum logic [3:0] {
      RK_NONE = 4'b0000,
      JUMP_LINK_EXCHANGE = 4'b0001,
      JUMP_VIA_REGISTER = 4'b0010,
      JUMP_VIA_REGISTER_BARRIER = 4'b0011,
      JUMP_LINK_VIA_REGISTER = 4'b0100,
      JUMP_LINK_VIA_REGISTER_BARRIER = 4'b0101,
      EXC_ENTRY = 4'b0110,
      DEBUG_ENTRY = 4'b0111,
      ERROR_ENTRY = 4'b1000,
      EXC_RETURN = 4'b1001,
      COP_OP = 4'b1010
   } retire_kind_t;

   typedef struct packed {
      logic valid;
      retire_kind_t kind;
      logic [31:0] srcValue;
      logic vectorFromBase;
      logic retPcBit0;
      logic [1:0] copNum;
   } retire_t;

   typedef struct packed {
      logic valid;
      logic [31:0] targetPc;
      logic linkBit0;
      logic savedMode;
      logic reservedInstrExc;
      logic addrExcOnFetch;
      logic copUnusableExc;
   } result_t;

   typedef struct packed {
      logic valid;
      logic length32;
      logic [5:0] majorOpcode;
      logic [5:0] minorOpcode;
      logic minorAtLow;
      logic minorAtTwelve;
      logic immRightAligned;
      logic [2:0] regCount;
      logic [3:0][4:0] regField;
      logic [31:0] branchOffset;
   } decode_t;

   typedef enum logic [1:0] {
      BOOT_WAIT = 2'b00,
      BOOT_LOAD = 2'b01,
      BOOT_RUN = 2'b10
   } boot_state_t;

endpackage

// ==== test/isa_mode_decode_chk.sv ====
// Checker for the encoding mode flag and format decode, bound to the top module.
// Assumes straps stay constant between resets and retire events come from the pipe model.
`timescale 1ns/1ps
`default_nettype none

module isa_mode_decode_chk
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] encodingsStrap,
   input wire isa_mode_pkg::retire_t retireIn,
   input wire isa_mode_pkg::result_t resultOut,
   input wire logic fetchValid,
   input wire logic [31:0] fetchWord,
   input wire logic bigEndian,
   input wire isa_mode_pkg::decode_t decodeOut,
   input wire logic [31:0] probeRdData,
   input wire logic modeFlag,
   input wire logic bootDone
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // Shorthands; events before boot are ignored, so all checks wait for it
   wire both = encodingsStrap[1];
   wire take = retireIn.valid && bootDone;
   wire isa_mode_pkg::retire_kind_t kind = retireIn.kind;
   wire srcBit0 = retireIn.srcValue[0];
   wire [30:0] srcHigh = retireIn.srcValue[31:1];
   wire retBit0 = retireIn.retPcBit0;
   wire [5:0] topMajor = fetchWord[31:26];
   wire [5:0] firstMajor = bigEndian ? fetchWord[31:26] : fetchWord[15:10];

   property p_jr;
      take && both && kind == isa_mode_pkg::JUMP_VIA_REGISTER |=>
         modeFlag == $past(srcBit0) && resultOut.targetPc == {$past(srcHigh), 1'b0};
   endproperty
   a_jr: assert property (p_jr) else $error("register jump mode or target wrong");
   property p_link;
      take && both && kind == isa_mode_pkg::JUMP_LINK_VIA_REGISTER |=>
         resultOut.valid && resultOut.linkBit0 == $past(modeFlag);
   endproperty
   a_link: assert property (p_link) else $error("link bit 0 wrong");
   property p_jump_link_exchange;
      take && both && kind == isa_mode_pkg::JUMP_LINK_EXCHANGE |=> modeFlag != $past(modeFlag);
   endproperty
   a_jump_link_exchange: assert property (p_jump_link_exchange) else $error("exchange jump kept mode");
   property p_ri;
      take && !both && kind == isa_mode_pkg::JUMP_LINK_EXCHANGE |=> resultOut.reservedInstrExc;
   endproperty
   a_ri: assert property (p_ri) else $error("exchange jump not refused");
   property p_ret;
      take && both && kind == isa_mode_pkg::EXC_RETURN |=> modeFlag == $past(retBit0);
   endproperty
   a_ret: assert property (p_ret) else $error("return did not restore mode");
   property p_fix;
      bootDone && !both |-> modeFlag == encodingsStrap[0];
   endproperty
   a_fix: assert property (p_fix) else $error("single encoding mode moved");
   property p_mirror;
      (bootDone && $stable(modeFlag)) [*3] |-> probeRdData[isa_mode_pkg::DBG_MODE_BIT] == modeFlag;
   endproperty
   a_mirror: assert property (p_mirror) else $error("mode mirror stale");
   property p_base;
      bootDone && fetchValid && !modeFlag |=> decodeOut.length32
         && decodeOut.majorOpcode == $past(topMajor) && decodeOut.branchOffset[1:0] == 2'h0;
   endproperty
   a_base: assert property (p_base) else $error("base decode wrong");
   property p_comp;
      bootDone && fetchValid && modeFlag |=>
         decodeOut.majorOpcode == $past(firstMajor) && !decodeOut.branchOffset[0];
   endproperty
   a_comp: assert property (p_comp) else $error("compressed decode wrong");
endmodule // isa_mode_decode_chk

bind isa_mode_decode isa_mode_decode_chk chk (.clock(clock), .rst(rst),
   .encodingsStrap(encodingsStrap), .retireIn(retireIn), .resultOut(resultOut),
   .fetchValid(fetchValid), .fetchWord(fetchWord), .bigEndian(bigEndian),
   .decodeOut(decodeOut), .probeRdData(probeRdData), .modeFlag(modeFlag), .bootDone(bootDone));

`default_nettype wire

// ==== test/isa_mode_decode_tb_top.sv ====
// Testbench for the mode flag and format decoder under several strap settings.
// Assumes the pipe model drives retire, fetch and probe traffic.
`timescale 1ns/1ps
`default_nettype none

module isa_mode_decode_tb_top;
   localparam logic [7:0] CFG = isa_mode_pkg::CFG_THREE_OFFSET;
   localparam logic [7:0] DBG = isa_mode_pkg::DEBUG_CTL_OFFSET;
   logic clock, rst, excEncodingStrap, debugEncodingStrap, regWrStrobe, regRdStrobe;
   logic [1:0] encodingsStrap;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, probeWrData, probeRdData, fetchWord;
   logic probeWrStrobe, fetchValid, bigEndian, modeFlag, bootDone;
   isa_mode_pkg::retire_t retireIn;
   isa_mode_pkg::result_t resultOut, res;
   isa_mode_pkg::decode_t decodeOut, dec;
   int mismatches, nChecks;
   isa_mode_pkg::retire_kind_t jk[4] = '{isa_mode_pkg::JUMP_VIA_REGISTER,
      isa_mode_pkg::JUMP_VIA_REGISTER_BARRIER, isa_mode_pkg::JUMP_LINK_VIA_REGISTER,
      isa_mode_pkg::JUMP_LINK_VIA_REGISTER_BARRIER};

   isa_mode_decode dut (.clock(clock), .rst(rst), .encodingsStrap(encodingsStrap),
      .excEncodingStrap(excEncodingStrap), .debugEncodingStrap(debugEncodingStrap),
      .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
      .regRdStrobe(regRdStrobe), .regRdData(regRdData), .probeWrStrobe(probeWrStrobe),
      .probeWrData(probeWrData), .probeRdData(probeRdData), .retireIn(retireIn),
      .resultOut(resultOut), .fetchValid(fetchValid), .fetchWord(fetchWord),
      .bigEndian(bigEndian), .decodeOut(decodeOut), .modeFlag(modeFlag), .bootDone(bootDone));
   isa_pipe_model pm (.clock(clock), .resultOut(resultOut), .decodeOut(decodeOut),
      .retireIn(retireIn), .fetchValid(fetchValid), .fetchWord(fetchWord),
      .bigEndian(bigEndian), .probeWrStrobe(probeWrStrobe), .probeWrData(probeWrData));

   // 250 MHz core clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkMode(input logic e);
      chk({31'h0, modeFlag}, {31'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      regWrStrobe <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      regRdStrobe <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRdStrobe <= 1'b0;
      #1;
      chk(regRdData, exp);
   endtask
   // Reset held three cycles from an edge, then a bounded wait for boot
   task automatic boot(input logic [1:0] s, input logic e, input logic d);
      @(posedge clock);
      rst <= 1'b1;
      encodingsStrap <= s;
      excEncodingStrap <= e;
      debugEncodingStrap <= d;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 20 && bootDone !== 1'b1; i++) @(posedge clock);
      chk({31'h0, bootDone}, 32'h1);
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && nChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Run is little over a hundred cycles; the limit leaves wide margin
   initial
   begin
      #20000;
      mismatches++;
      wrap_up();
   end

   initial
   begin
      {rst, excEncodingStrap, debugEncodingStrap} = 3'h4;
      {encodingsStrap, regAddr, regWrData, regWrStrobe, regRdStrobe} = '0;
      mismatches = 0;
      nChecks = 0;
      boot(2'h2, 1'b0, 1'b0);
      chkMode(1'b0);
      rd(CFG, 32'h0000_8000);
      rd(8'h08, 32'h0);
      wr(CFG, 32'h0001_0000);
      rd(CFG, 32'h0001_8000);
      wr(DBG, 32'h0000_0003);
      rd(DBG, 32'h0);
      // Base long jump with negative offset
      pm.fetch(32'h0bff_ffff, 1'b1, dec);
      chk(dec.branchOffset, 32'hffff_fffc);
      chk({31'h0, dec.immRightAligned}, 32'h1);
      chk({26'h0, dec.majorOpcode}, 32'h2);
      chk({31'h0, dec.length32}, 32'h1);
      pm.retire(isa_mode_pkg::JUMP_VIA_REGISTER, 32'h0000_1001, 2'h0, res);
      chkMode(1'b1);
      chk(res.targetPc, 32'h0000_1000);
      // Compressed formats in both byte orders
      pm.fetch(32'h0021_3840, 1'b1, dec);
      chk({29'h0, dec.regCount}, 32'h4);
      chk({31'h0, dec.minorAtLow}, 32'h1);
      pm.fetch(32'h0001_d400, 1'b0, dec);
      chk({26'h0, dec.majorOpcode}, 32'h35);
      chk(dec.branchOffset, 32'h2);
      pm.fetch(32'h2000_5123, 1'b1, dec);
      chk({31'h0, dec.minorAtTwelve}, 32'h1);
      chk({26'h0, dec.minorOpcode}, 32'h5);
      pm.fetch(32'h0400_0000, 1'b1, dec);
      chk({31'h0, dec.length32}, 32'h0);
      // Every register jump form; mode alternates with source bit 0
      for (int i = 0; i < 4; i++)
      begin
         pm.retire(jk[i], 32'h0000_2000 | i, 2'h0, res);
         chkMode(i[0]);
         chk(res.targetPc, 32'h0000_2000 | (i & 2));
         if (i > 1) chk({31'h0, res.linkBit0}, {31'h0, ~i[0]});
      end
      pm.retire(isa_mode_pkg::JUMP_LINK_EXCHANGE, 32'h0, 2'h0, res);
      chkMode(1'b0);
      pm.retire(isa_mode_pkg::EXC_ENTRY, 32'h0, 2'h2, res);
      chk({31'h0, res.savedMode}, 32'h0);
      chkMode(1'b1);
      pm.retire(isa_mode_pkg::EXC_ENTRY, 32'h0, 2'h0, res);
      chk({31'h0, res.savedMode}, 32'h1);
      chkMode(1'b0);
      pm.retire(isa_mode_pkg::EXC_RETURN, 32'h0, 2'h1, res);
      chkMode(1'b1);
      pm.retire(isa_mode_pkg::EXC_RETURN, 32'h0, 2'h0, res);
      chkMode(1'b0);
      pm.probe(32'h0000_0001);
      pm.retire(isa_mode_pkg::DEBUG_ENTRY, 32'h0, 2'h2, res);
      chk({31'h0, res.savedMode}, 32'h0);
      chkMode(1'b1);
      rd(DBG, 32'h0000_0003);
      chk(probeRdData, 32'h0000_0003);
      for (int c = 0; c < 4; c++)
      begin
         pm.retire(isa_mode_pkg::COP_OP, 32'h0, c[1:0], res);
         chk({31'h0, res.copUnusableExc}, {31'h0, ~isa_mode_pkg::COP_IMPLEMENTED[c]});
      end
      pm.retire(isa_mode_pkg::ERROR_ENTRY, 32'h0, 2'h0, res);
      chk({31'h0, res.savedMode}, 32'h1);
      chkMode(1'b0);
      // Base only: exchange refused, mismatched bit 0 faults; then compressed only, then both
      boot(2'h0, 1'b0, 1'b0);
      rd(CFG, 32'h0);
      pm.retire(isa_mode_pkg::JUMP_LINK_EXCHANGE, 32'h0, 2'h0, res);
      chk({31'h0, res.reservedInstrExc}, 32'h1);
      pm.retire(isa_mode_pkg::JUMP_VIA_REGISTER, 32'h0000_1001, 2'h0, res);
      chk({31'h0, res.addrExcOnFetch}, 32'h1);
      chkMode(1'b0);
      pm.retire(isa_mode_pkg::JUMP_VIA_REGISTER, 32'h0000_1000, 2'h0, res);
      chk({31'h0, res.addrExcOnFetch}, 32'h0);
      boot(2'h1, 1'b0, 1'b0);
      chkMode(1'b1);
      pm.retire(isa_mode_pkg::JUMP_VIA_REGISTER, 32'h0000_1000, 2'h0, res);
      chk({31'h0, res.addrExcOnFetch}, 32'h1);
      boot(2'h3, 1'b1, 1'b1);
      chkMode(1'b1);
      rd(CFG, 32'h0001_c000);
      rd(DBG, 32'h0000_0003);
      wrap_up();
   end
endmodule // isa_mode_decode_tb_top

`default_nettype wire

// ==== test/isa_pipe_model.sv ====
// Model of the fetch path, pipeline retirement and debug probe beside the decoder.
// Assumes tasks are called one at a time from the testbench.
`timescale 1ns/1ps
`default_nettype none

module isa_pipe_model
(
   input wire logic clock,
   input wire isa_mode_pkg::result_t resultOut,
   input wire isa_mode_pkg::decode_t decodeOut,
   output isa_mode_pkg::retire_t retireIn,
   output logic fetchValid,
   output logic [31:0] fetchWord,
   output logic bigEndian,
   output logic probeWrStrobe,
   output logic [31:0] probeWrData
);
   // Quiet bus at time zero
   initial
   begin
      retireIn = '0;
      {fetchValid, fetchWord, bigEndian, probeWrStrobe, probeWrData} = '0;
   end

   // One retire event; x drives vector-from-base (bit 1), return bit 0 and coprocessor
   task automatic retire(input isa_mode_pkg::retire_kind_t k, input logic [31:0] s,
      input logic [1:0] x, output isa_mode_pkg::result_t r);
      @(posedge clock);
      retireIn <= '{1'b1, k, s, x[1], x[0], x};
      @(posedge clock);
      retireIn <= ~retireIn; // Drops valid, scrambles stale fields
      #1;
      r = resultOut;
   endtask

   // One fetch word; stale word is inverted after release
   task automatic fetch(input logic [31:0] w, input logic be, output isa_mode_pkg::decode_t d);
      @(posedge clock);
      fetchValid <= 1'b1;
      fetchWord <= w;
      bigEndian <= be;
      @(posedge clock);
      fetchValid <= 1'b0;
      fetchWord <= ~w;
      #1;
      d = decodeOut;
   endtask

   // Probe write of the debug handler encoding bit
   task automatic probe(input logic [31:0] w);
      @(posedge clock);
      probeWrStrobe <= 1'b1;
      probeWrData <= w;
      @(posedge clock);
      probeWrStrobe <= 1'b0;
      probeWrData <= ~w;
   endtask
endmodule // isa_pipe_model

`default_nettype wire
